// ### verilog/dac_input_register_update.sv
// register front end and shadow update of the 10-bit converter
// Behaviour
// RULE_01: left-align bit selects byte justification
// RULE_02: alignment change applies at next high write; in trigger mode the code reads it live and applies it at the next trigger load
// RULE_03: output-enable routes result to analog pin
// RULE_04: enable bit switches converter on
// RULE_05: low write blocks update until high write
// RULE_06: right-aligned layout, bytes reset zero
// RULE_07: left-aligned layout, high byte enough
// RULE_08: converted value held in hidden shadow
// RULE_09: manual mode: high write loads shadow
// RULE_10: trigger mode: load only on trigger
// RULE_11: trigger needs low then high, else reload
// RULE_12: software writes low byte before high
// RULE_13: bit seven enables trigger-edge updates
// RULE_14: three-bit field picks one of eight sources
// RULE_15: update on flag rise, interrupt enable ignored
// RULE_16: reset clears shadow and pending lock
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "dac_front_map.svh"
module dac_input_register_update (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   // axi4-lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // trigger event flags, same clock
   input wire logic [7:0] triggerFlags,
   // converter side
   output logic [9:0] convValue,
   output logic converterOn,
   output logic analogOutDriveEn,
   output logic internalUseOnly
);
   // ================================================================
   // registers
   logic [7:0] converterControlReg;
   logic [7:0] valueHighByte;
   logic [7:0] valueLowByte;
   logic [9:0] shadow;
   logic lowPending;
   logic highSinceLow;
   logic [7:0] next_converterControlReg;
   logic [7:0] next_valueHighByte;
   logic [7:0] next_valueLowByte;
   logic [9:0] next_shadow;
   logic next_lowPending;
   logic next_highSinceLow;
   logic [9:0] assembled;
   logic [7:0] flagRise;
   logic trigEvent;
   logic loadShadow;
   logic wrHigh;
   logic wrLow;
   logic wrCtrl;
   logic autoTrig;
   logic [2:0] trigSel;

   // ================================================================
   // bus slave
   dac_front_pkg::bus_state_e wState;
   dac_front_pkg::bus_state_e next_wState;
   dac_front_pkg::bus_state_e rState;
   dac_front_pkg::bus_state_e next_rState;
   logic [11:0] awAddr;
   logic [11:0] next_awAddr;
   logic awHeld;
   logic next_awHeld;
   logic [31:0] wData;
   logic [31:0] next_wData;
   logic [3:0] wStrb;
   logic [3:0] next_wStrb;
   logic wHeld;
   logic next_wHeld;
   logic [1:0] bResp;
   logic [1:0] next_bResp;
   logic [31:0] rData;
   logic [31:0] next_rData;
   logic [1:0] rResp;
   logic [1:0] next_rResp;
   logic wCommit;
   logic awKnown;
   logic [11:0] wrAddr;

   assign s_axi_awready = clkEn & (wState == dac_front_pkg::BUS_IDLE) & ~awHeld;
   assign s_axi_wready = clkEn & (wState == dac_front_pkg::BUS_IDLE) & ~wHeld;
   assign s_axi_bvalid = (wState == dac_front_pkg::BUS_RESP);
   assign s_axi_bresp = bResp;
   assign s_axi_arready = clkEn & (rState == dac_front_pkg::BUS_IDLE);
   assign s_axi_rvalid = (rState == dac_front_pkg::BUS_RESP);
   assign s_axi_rdata = rData;
   assign s_axi_rresp = rResp;

   // address and data may arrive in either order; commit when both held
   assign wCommit = awHeld & wHeld & (wState == dac_front_pkg::BUS_IDLE);
   assign wrAddr = {awAddr[11:2], 2'b00};
   assign awKnown = (wrAddr == `OFF_CONTROL) | (wrAddr == `OFF_HIGH) |
      (wrAddr == `OFF_LOW) | (wrAddr == `OFF_SHADOW) | (wrAddr == `OFF_STATUS);
   // only byte lane 0 carries data; narrower registers ignore upper lanes
   assign wrCtrl = wCommit & wStrb[0] & (wrAddr == `OFF_CONTROL);
   assign wrHigh = wCommit & wStrb[0] & (wrAddr == `OFF_HIGH);
   assign wrLow = wCommit & wStrb[0] & (wrAddr == `OFF_LOW);

   always_comb begin
      next_wState = wState;
      next_awAddr = awAddr;
      next_awHeld = awHeld;
      next_wData = wData;
      next_wStrb = wStrb;
      next_wHeld = wHeld;
      next_bResp = bResp;
      case (wState)
         dac_front_pkg::BUS_IDLE: begin
            if (s_axi_awvalid && s_axi_awready) begin
               next_awAddr = s_axi_awaddr;
               next_awHeld = 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               next_wData = s_axi_wdata;
               next_wStrb = s_axi_wstrb;
               next_wHeld = 1'b1;
            end
            if (wCommit) begin
               next_awHeld = 1'b0;
               next_wHeld = 1'b0;
               next_bResp = awKnown ? `AXI_OKAY : `AXI_DECERR;
               next_wState = dac_front_pkg::BUS_RESP;
            end
         end
         dac_front_pkg::BUS_RESP: begin
            if (s_axi_bready) begin
               next_wState = dac_front_pkg::BUS_IDLE;
            end
         end
         default: begin
            next_wState = dac_front_pkg::BUS_IDLE;
         end
      endcase
      if (!clkEn) begin
         next_wState = wState;
         next_awAddr = awAddr;
         next_awHeld = awHeld;
         next_wData = wData;
         next_wStrb = wStrb;
         next_wHeld = wHeld;
         next_bResp = bResp;
      end
   end

   always_comb begin
      logic [11:0] ra;
      ra = {s_axi_araddr[11:2], 2'b00};
      next_rState = rState;
      next_rData = rData;
      next_rResp = rResp;
      case (rState)
         dac_front_pkg::BUS_IDLE: begin
            if (s_axi_arvalid) begin
               next_rState = dac_front_pkg::BUS_RESP;
               next_rResp = `AXI_OKAY;
               case (ra)
                  `OFF_CONTROL: next_rData = {24'h00_0000, converterControlReg};
                  `OFF_HIGH: next_rData = {24'h00_0000, valueHighByte};
                  `OFF_LOW: next_rData = {24'h00_0000, valueLowByte};
                  // debug view; software still cannot alter the shadow
                  `OFF_SHADOW: next_rData = {22'h00_0000, shadow};
                  `OFF_STATUS: next_rData = {30'h0000_0000, highSinceLow, lowPending};
                  default: begin
                     next_rData = 32'h0000_0000;
                     next_rResp = `AXI_DECERR;
                  end
               endcase
            end
         end
         dac_front_pkg::BUS_RESP: begin
            if (s_axi_rready) begin
               next_rState = dac_front_pkg::BUS_IDLE;
            end
         end
         default: begin
            next_rState = dac_front_pkg::BUS_IDLE;
         end
      endcase
      if (!clkEn) begin
         next_rState = rState;
         next_rData = rData;
         next_rResp = rResp;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wState <= dac_front_pkg::BUS_IDLE;
         rState <= dac_front_pkg::BUS_IDLE;
         awAddr <= 12'h000;
         awHeld <= 1'b0;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         wHeld <= 1'b0;
         bResp <= `AXI_OKAY;
         rData <= 32'h0000_0000;
         rResp <= `AXI_OKAY;
      end else begin
         wState <= next_wState;
         rState <= next_rState;
         awAddr <= next_awAddr;
         awHeld <= next_awHeld;
         wData <= next_wData;
         wStrb <= next_wStrb;
         wHeld <= next_wHeld;
         bResp <= next_bResp;
         rData <= next_rData;
         rResp <= next_rResp;
      end
   end

   // ================================================================
   // trigger selection
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_rise
         rise_detect u_rise (
            .mclk(mclk),
            .rst_n(rst_n),
            .clkEn(clkEn),
            .flag(triggerFlags[gi]),
            .rise(flagRise[gi])
         ); // [RULE_15]
      end
   endgenerate

   assign autoTrig = converterControlReg[`BIT_AUTO_TRIG];
   assign trigSel = converterControlReg[`TSEL_MSB:`TSEL_LSB];
   assign trigEvent = flagRise[trigSel]; // [RULE_14]

   // ================================================================
   // shadow update
   // alignment read live from control, bytes as they stand now
   value_align u_align (
      .leftAlign(converterControlReg[`BIT_LEFT_ALIGN]),
      .highByte(valueHighByte),
      .lowByte(valueLowByte),
      .value(assembled)
   );

   // trigger mode: a low write holds updates back until high is written
   assign loadShadow = autoTrig ? (trigEvent & ~lowPending) : wrHigh; // [RULE_09] [RULE_10] [RULE_13] [RULE_05] [RULE_11]

   always_comb begin
      next_converterControlReg = converterControlReg;
      next_valueHighByte = valueHighByte;
      next_valueLowByte = valueLowByte;
      next_shadow = shadow;
      next_lowPending = lowPending;
      next_highSinceLow = highSinceLow;
      if (wrCtrl) begin
         next_converterControlReg = wData[7:0] & `CONTROL_WMASK;
      end
      if (wrLow) begin
         next_valueLowByte = wData[7:0];
         next_lowPending = 1'b1; // [RULE_05]
         next_highSinceLow = 1'b0;
      end
      if (wrHigh) begin
         next_valueHighByte = wData[7:0];
         next_lowPending = 1'b0; // [RULE_05] [RULE_11]
         next_highSinceLow = 1'b1;
      end
      if (!autoTrig && wrHigh) begin
         // new high byte must reach the shadow in the same write
         if (converterControlReg[`BIT_LEFT_ALIGN]) begin
            next_shadow = {wData[7:0], valueLowByte[7:6]}; // [RULE_02] [RULE_09]
         end else begin
            next_shadow = {wData[1:0], valueLowByte}; // [RULE_02] [RULE_09]
         end
      end else if (loadShadow) begin
         next_shadow = assembled; // [RULE_08] [RULE_11]
      end
      if (!clkEn) begin
         next_converterControlReg = converterControlReg;
         next_valueHighByte = valueHighByte;
         next_valueLowByte = valueLowByte;
         next_shadow = shadow;
         next_lowPending = lowPending;
         next_highSinceLow = highSinceLow;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         converterControlReg <= `RST_CONTROL;
         valueHighByte <= `RST_BYTE; // [RULE_06]
         valueLowByte <= `RST_BYTE; // [RULE_06]
         shadow <= `RST_SHADOW; // [RULE_16]
         lowPending <= 1'b0; // [RULE_16]
         highSinceLow <= 1'b0;
      end else begin
         converterControlReg <= next_converterControlReg;
         valueHighByte <= next_valueHighByte;
         valueLowByte <= next_valueLowByte;
         shadow <= next_shadow;
         lowPending <= next_lowPending;
         highSinceLow <= next_highSinceLow;
      end
   end

   // ================================================================
   // converter outputs
   assign convValue = shadow;
   assign converterOn = converterControlReg[`BIT_CONV_ON]; // [RULE_04]
   assign analogOutDriveEn = converterControlReg[`BIT_CONV_ON] &
      converterControlReg[`BIT_OUT_DRIVE]; // [RULE_03]
   assign internalUseOnly = converterControlReg[`BIT_CONV_ON] &
      ~converterControlReg[`BIT_OUT_DRIVE]; // [RULE_03]
endmodule // dac_input_register_update

// ### verilog/dac_front_map.svh
// register offsets, field positions, reset values for the converter front end
`ifndef DAC_FRONT_MAP_SVH
`define DAC_FRONT_MAP_SVH
// ====================================================================
// offsets
`define OFF_CONTROL 12'h000
`define OFF_HIGH 12'h004
`define OFF_LOW 12'h008
`define OFF_SHADOW 12'h00C
`define OFF_STATUS 12'h010
// ====================================================================
// control fields
`define BIT_CONV_ON 0
`define BIT_OUT_DRIVE 1
`define BIT_LEFT_ALIGN 2
`define TSEL_LSB 4
`define TSEL_MSB 6
`define BIT_AUTO_TRIG 7
`define CONTROL_WMASK 8'hF7
// ====================================================================
// reset values
`define RST_CONTROL 8'h00
`define RST_BYTE 8'h00
`define RST_SHADOW 10'h000
`define AXI_OKAY 2'b00
`define AXI_DECERR 2'b11
`endif

// ### verilog/dac_front_pkg.sv
// types for the converter front end
package dac_front_pkg;
   typedef enum logic [2:0] {
      TRIG_CMP0 = 3'h0,
      TRIG_CMP1 = 3'h1,
      TRIG_EXT0 = 3'h2,
      TRIG_T0_CMP = 3'h3,
      TRIG_T0_OVF = 3'h4,
      TRIG_T1_CMPB = 3'h5,
      TRIG_T1_OVF = 3'h6,
      TRIG_T1_CAPT = 3'h7
   } trigger_source_e;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_RESP = 2'b01
   } bus_state_e;
endpackage

// ### verilog/rise_detect.sv
// rising edge detector for one same-clock event flag
`timescale 1ns/1ps
module rise_detect (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   // flag in, pulse out
   input wire logic flag,
   output logic rise
);
   logic prev;
   logic next_prev;
   always_comb begin
      next_prev = clkEn ? flag : prev;
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prev <= 1'b0;
      end else begin
         prev <= next_prev;
      end
   end
   assign rise = clkEn & flag & ~prev;
endmodule // rise_detect

// ### verilog/value_align.sv
// assembles the 10-bit value from two bytes per alignment
`timescale 1ns/1ps
module value_align (
   // alignment and bytes
   input wire logic leftAlign,
   input wire logic [7:0] highByte,
   input wire logic [7:0] lowByte,
   // assembled value
   output logic [9:0] value
);
   always_comb begin
      if (leftAlign) begin
         value = {highByte, lowByte[7:6]}; // [RULE_01] [RULE_07]
      end else begin
         value = {highByte[1:0], lowByte}; // [RULE_01] [RULE_06]
      end
   end
endmodule // value_align

// ### dv/dac_input_register_update_monitor.sv
// bus timing and converter output checker
`timescale 1ns/1ps
module dac_input_register_update_monitor (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // converter side
   input wire logic [7:0] triggerFlags,
   input wire logic [9:0] convValue,
   input wire logic converterOn,
   input wire logic analogOutDriveEn,
   input wire logic internalUseOnly
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ====================================================================
   // sequences
   sequence bothTaken;
      clkEn && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // flag rise seen one edge back, when a trigger load lands
   sequence trigRise;
      |($past(triggerFlags) & ~$past(triggerFlags, 2));
   endsequence
   // ====================================================================
   // properties
   write_answer_a: assert property (bothTaken |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer late or early");
   read_answer_a: assert property (clkEn && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   bresp_drop_a: assert property (clkEn && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   rdata_drop_a: assert property (clkEn && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response not released");
   busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   shadow_cause_a: assert property (
      $changed(convValue) |-> $rose(s_axi_bvalid) or trigRise)
      else $error("shadow changed without cause");
   drive_split_a: assert property (converterOn |-> analogOutDriveEn != internalUseOnly)
      else $error("output routing wrong");
   conv_off_a: assert property (!converterOn |-> !analogOutDriveEn && !internalUseOnly)
      else $error("routing active while off");
endmodule // dac_input_register_update_monitor

bind dac_input_register_update dac_input_register_update_monitor mon_u (
   .mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .triggerFlags(triggerFlags), .convValue(convValue), .converterOn(converterOn),
   .analogOutDriveEn(analogOutDriveEn), .internalUseOnly(internalUseOnly)
);

// ### dv/dac_input_register_update_tb.sv
// self-checking bench of the converter front end
`timescale 1ns/1ps
`include "dac_front_map.svh"
module dac_input_register_update_tb;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] awAddr = 12'h000;
   logic [31:0] wData = 32'h0000_0000;
   logic [11:0] arAddr = 12'h000;
   logic awValid = 1'b0;
   logic wValid = 1'b0;
   logic bReady = 1'b0;
   logic arValid = 1'b0;
   logic rReady = 1'b0;
   logic [7:0] triggerFlags = 8'h00;
   logic clkEn = 1'b1;
   logic [3:0] wStrb = 4'h1;
   logic awReady, wReady, bValid, arReady, rValid;
   logic converterOn, analogOutDriveEn, internalUseOnly;
   logic [1:0] bResp, rResp;
   logic [31:0] rData, rdv;
   logic [9:0] convValue, expVal;
   logic la;
   logic [7:0] lo, hi;
   integer n_mismatch = 0;
   integer check_count = 0;
   integer seed = 32'h45cb_38dd;

   always #12.5 mclk = ~mclk;

   dac_input_register_update dut_u (
      .mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
      .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .triggerFlags(triggerFlags), .convValue(convValue),
      .converterOn(converterOn), .analogOutDriveEn(analogOutDriveEn),
      .internalUseOnly(internalUseOnly)
   );
   // ====================================================================
   // helpers
   function automatic logic [9:0] alignVal(input logic l, input logic [7:0] h, input logic [7:0] b);
      return l ? {h, b[7:6]} : {h[1:0], b};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // upper data bits are random: the block must ignore them
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge mclk);
      awAddr <= a;
      wData <= ($random(seed) & 32'hFFFF_FF00) | {24'h00_0000, d};
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      do begin
         @(posedge mclk);
         if (awValid && awReady) awValid <= 1'b0;
         if (wValid && wReady) wValid <= 1'b0;
      end while (!bValid);
      bReady <= 1'b0;
      check(bResp, er);
   endtask
   task automatic rd(input logic [11:0] a, input logic [1:0] er);
      @(posedge mclk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      do begin
         @(posedge mclk);
         if (arValid && arReady) arValid <= 1'b0;
      end while (!rValid);
      rReady <= 1'b0;
      rdv = rData;
      check(rResp, er);
   endtask
   task automatic pulse(input logic [2:0] s);
      @(posedge mclk);
      triggerFlags <= 8'h01 << s;
      @(posedge mclk);
      triggerFlags <= 8'h00;
      repeat (2) @(posedge mclk);
   endtask
   task automatic close_out;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ====================================================================
   // watchdog, far beyond the few hundred cycles needed
   initial begin
      #(25 * 20000);
      n_mismatch++;
      close_out;
   end
   // ====================================================================
   // main sequence
   initial begin
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      expVal = 10'h000;
      for (int i = 0; i < 5; i++) begin
         rd(12'(i * 4), `AXI_OKAY);
         check(rdv, 32'h0000_0000);
      end
      rd(12'h100, `AXI_DECERR);
      wr(12'h100, 8'h55, `AXI_DECERR);
      wr(`OFF_CONTROL, 8'hFF, `AXI_OKAY);
      rd(`OFF_CONTROL, `AXI_OKAY);
      check(rdv, 32'h0000_00F7);
      for (int i = 0; i < 4; i++) begin
         wr(`OFF_CONTROL, 8'(i), `AXI_OKAY);
         check(converterOn, i[0]);
         check(analogOutDriveEn, i == 3);
         check(internalUseOnly, i == 1);
      end
      // manual mode, first two passes pinned to full-scale corners
      for (int i = 0; i < 16; i++) begin
         {la, lo, hi} = 17'($random(seed));
         if (i < 2) {la, lo, hi} = {i[0], 16'hFFFF};
         wr(`OFF_CONTROL, {5'h00, la, 2'b01}, `AXI_OKAY);
         check(convValue, expVal);
         wr(`OFF_LOW, lo, `AXI_OKAY);
         check(convValue, expVal);
         wr(`OFF_HIGH, hi, `AXI_OKAY);
         expVal = alignVal(la, hi, lo);
         check(convValue, expVal);
      end
      // lane 0 off: high write answers okay but must not land
      wStrb <= 4'hE;
      wr(`OFF_HIGH, ~hi, `AXI_OKAY);
      wStrb <= 4'h1;
      check(convValue, expVal);
      rd(`OFF_HIGH, `AXI_OKAY);
      check(rdv, {24'h00_0000, hi});
      // trigger mode over every source
      for (int s = 0; s < 8; s++) begin
         {la, lo, hi} = 17'($random(seed));
         wr(`OFF_CONTROL, {1'b1, 3'(s), 1'b0, la, 2'b11}, `AXI_OKAY);
         wr(`OFF_LOW, lo, `AXI_OKAY);
         pulse(3'(s));
         check(convValue, expVal);
         wr(`OFF_HIGH, hi, `AXI_OKAY);
         check(convValue, expVal);
         pulse(3'(s + 1));
         check(convValue, expVal);
         pulse(3'(s));
         expVal = alignVal(la, hi, lo);
         check(convValue, expVal);
         wr(`OFF_HIGH, ~hi, `AXI_OKAY);
         pulse(3'(s));
         expVal = alignVal(la, ~hi, lo);
         check(convValue, expVal);
      end
      // frozen clock enable: a trigger rise is not seen at all
      wr(`OFF_HIGH, hi, `AXI_OKAY);
      clkEn <= 1'b0;
      pulse(3'h7);
      check(convValue, expVal);
      clkEn <= 1'b1;
      pulse(3'h7);
      expVal = alignVal(la, hi, lo);
      check(convValue, expVal);
      // reset with a low-byte lock pending
      wr(`OFF_LOW, 8'hA5, `AXI_OKAY);
      rd(`OFF_STATUS, `AXI_OKAY);
      check(rdv, 32'h0000_0001);
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      check(convValue, 10'h000);
      rst_n <= 1'b1;
      rd(`OFF_STATUS, `AXI_OKAY);
      check(rdv, 32'h0000_0000);
      close_out;
   end
endmodule // dac_input_register_update_tb
